// file: inc/chan_adapt_map.svh
`ifndef CHAN_ADAPT_MAP_SVH
`define CHAN_ADAPT_MAP_SVH
// register offsets
`define OFS_EYE_RANGE_STATUS 8'h29
`define OFS_EYE_TIMER_THR 8'h2A
`define OFS_DFE_MERIT_CTRL 8'h2C
`define OFS_DRIVER_SWING 8'h2D
`define OFS_RATE_LOCK_CTRL 8'h2F
`define OFS_EYE_INT_PRBS 8'h30
`define OFS_ADAPT_MODE 8'h31
`define OFS_EYE_INT_THR 8'h32
`define OFS_HANDOFF_THR 8'h33
`define OFS_LATER_TAP_LIMIT 8'h34
`define OFS_FIRST_TAP_LIMIT 8'h35
`define OFS_INT_CLK_MODE 8'h36
`define OFS_CTLE_START_INDEX 8'h39
`define OFS_LOW_RATE_BOOST 8'h3A
`define OFS_EYE_LOCK_CTRL 8'h3E
`define OFS_EYE_LOCK_THR 8'h6A
`define OFS_MERIT_TERM_A 8'h6B
`define OFS_MERIT_TERM_B 8'h6C
`define OFS_MERIT_TERM_C 8'h6D
`define OFS_ALT_MERIT_EN 8'h6E
`define OFS_CTLE_LOOK_AHEAD 8'h70
`define OFS_TAP1_OBSERVE 8'h71
`define OFS_TAP2_OBSERVE 8'h72
`define OFS_TAP5_OBSERVE 8'h75
// writable-bit masks
`define MSK_DFE_MERIT_CTRL 8'h3F
`define MSK_DRIVER_SWING 8'h07
`define MSK_RATE_LOCK_CTRL 8'hFF
`define MSK_EYE_INT_PRBS 8'h0B
`define MSK_ADAPT_MODE 8'h78
`define MSK_LATER_TAP_LIMIT 8'h0F
`define MSK_FIRST_TAP_LIMIT 8'h1F
`define MSK_INT_CLK_MODE 8'h77
`define MSK_CTLE_START_INDEX 8'h1F
`define MSK_EYE_LOCK_CTRL 8'h80
`define MSK_ALT_MERIT_EN 8'hC0
`define MSK_CTLE_LOOK_AHEAD 8'h07
// reset values
`define RST_EYE_TIMER_THR 8'h30
`define RST_DFE_MERIT_CTRL 8'h32
`define RST_DRIVER_SWING 8'h00
`define RST_RATE_LOCK_CTRL 8'h06
`define RST_EYE_INT_PRBS 8'h00
`define RST_ADAPT_MODE 8'h20
`define RST_EYE_INT_THR 8'h11
`define RST_HANDOFF_THR 8'h88
`define RST_LATER_TAP_LIMIT 8'h0F
`define RST_FIRST_TAP_LIMIT 8'h1F
`define RST_INT_CLK_MODE 8'h31
`define RST_CTLE_START_INDEX 8'h00
`define RST_LOW_RATE_BOOST 8'hA5
`define RST_EYE_LOCK_CTRL 8'h80
`define RST_EYE_LOCK_THR 8'h44
`define RST_MERIT_TERM 8'h00
`define RST_ALT_MERIT_EN 8'h00
`define RST_CTLE_LOOK_AHEAD 8'h03
// field positions
`define BIT_INDEX_OVERRIDE 3
`define BIT_PPM_CHECK 2
`define BIT_FALSE_LOCK_OFF 1
`define BIT_CTLE_ADAPT_GO 0
`define BIT_EYE_INT_FLAG 4
`define BIT_PRBS_ENABLE 3
`define BIT_EYE_INT_ENABLE 6
`define BIT_CAP_RANGE_OVERRIDE 2
`define BIT_EYE_LOCK_WATCH 7
`define BIT_ALT_MERIT_CTLE 7
`define BIT_ALT_MERIT_DFE 6
`define BIT_TAP1_POL 5
`define BIT_TAPN_POL 4
`endif

// file: inc/chan_adapt_pkg.sv
package chan_adapt_pkg;
  // one byte access from the host side
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one dfe tap as the equalizer applies it
  typedef struct packed {
    logic pol;
    logic [4:0] weight;
  } tap_obs_t;

  // settings handed to the adaptation logic
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] subrate;
    logic ppmCheckOn;
    logic falseLockOn;
    logic ctleAdaptGo;
    logic [4:0] ctleStartIndex;
    logic startPointOverride;
    logic [1:0] adaptMode;
    logic [1:0] ctleMeritKind;
    logic [1:0] feedbackMeritKind;
    logic [3:0] feedbackLookAhead;
    logic [2:0] ctleLookAheadCount;
    logic [3:0] handoffHoriz;
    logic [3:0] handoffVert;
    logic [4:0] firstTapLimit;
    logic [3:0] laterTapLimit;
    logic altMeritCtle;
    logic altMeritDfe;
    logic [7:0] meritTermA;
    logic [7:0] meritTermB;
    logic [7:0] meritTermC;
    logic eyeLockWatchOn;
    logic [3:0] eyeLockVert;
    logic [3:0] eyeLockHoriz;
    logic [7:0] eyeTimerThr;
    logic [1:0] lowRateBoostStage0;
    logic [1:0] lowRateBoostStage1;
    logic [1:0] lowRateBoostStage2;
    logic [1:0] lowRateBoostStage3;
    logic prbsEnable;
    logic [1:0] prbsPattern;
    logic [1:0] refClockMode;
    logic capRangeOverride;
    logic [1:0] capRangeValue;
    logic [2:0] driverSwing;
    logic [3:0] eyeIntHoriz;
    logic [3:0] eyeIntVert;
  } adapt_cfg_t;
endpackage : chan_adapt_pkg

// file: core/tap_clamp.sv
`timescale 1ns/1ns
// limits applied dfe taps to the programmed absolute maxima
module tap_clamp (
  // unclamped taps from adaptation
  input wire chan_adapt_pkg::tap_obs_t rawTap [5],
  // limits
  input wire logic [4:0] firstLimit,
  input wire logic [3:0] laterLimit,
  // clamped taps
  output chan_adapt_pkg::tap_obs_t clampTap [5]
);
  function automatic logic [4:0] clampWeight(input logic [4:0] w, input logic [4:0] lim);
    clampWeight = (w > lim) ? lim : w;
  endfunction : clampWeight

  assign clampTap[0] = '{pol: rawTap[0].pol, weight: clampWeight(rawTap[0].weight, firstLimit)};
  genvar i;
  generate
    for (i = 1; i < 5; i++) begin : gLater
      assign clampTap[i] = '{pol: rawTap[i].pol,
                             weight: clampWeight({1'b0, rawTap[i].weight[3:0]}, {1'b0, laterLimit})};
    end
  endgenerate
endmodule : tap_clamp

// file: core/retimer_channel_adapt_cfg_regs.sv
`timescale 1ns/1ns
`include "chan_adapt_map.svh"
// Notes on behaviour
// - ppm lock check enable resets to one
// - false-lock control resets one, meaning disabled
// - start index applies only when override set
// - eye interrupt flag rises on loop event
// - eye interrupt raised only when enabled
// - reading flag register clears eye flag
// - interrupt thresholds horizontal high, vertical low
// - handoff thresholds horizontal high, reset eight
// - dfe taps clamped to programmed limits
// - tap one polarity and weight readable
// - taps two to five readable, consecutive
// - adaptation mode and ctle merit kind
// - dfe merit kind and look-ahead counter
// - ctle look-ahead count resets to three
// - alternate merit enables and three terms
// - eye lock thresholds vertical high, four
// - eye lock watch enable resets one
// - eye timer threshold full byte, eye_interrupt_and_prbs_control
// - eye voltage range in use readonly
// - fixed low-rate boosts per stage
// - prbs enable and pattern select
// - clock mode, cap range override and value
module retimer_channel_adapt_cfg_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register access from the selected-channel port
  input wire chan_adapt_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  output logic regRvalid,
  // state from the recovery loop and equalizer
  input wire logic eyeIntEvent,
  input wire logic [1:0] eyeRangeInUse,
  input wire chan_adapt_pkg::tap_obs_t rawTap [5],
  // settings to the adaptation logic
  output chan_adapt_pkg::adapt_cfg_t adaptCfg,
  output logic eyeIntPending,
  output chan_adapt_pkg::tap_obs_t appliedTap [5]
);
  logic [7:0] eyeTimerThr_ff, dfeMerit_ff, driverSwing_ff, rateLock_ff, eyeIntPrbs_ff;
  logic [7:0] adaptMode_ff, eyeIntThr_ff, handoffThr_ff, laterLimit_ff, firstLimit_ff;
  logic [7:0] intClkMode_ff, startIndex_ff, lowRateBoost_ff, eyeLockCtrl_ff, eyeLockThr_ff;
  logic [7:0] meritA_ff, meritB_ff, meritC_ff, altMerit_ff, ctleLook_ff;
  logic eyeFlag_ff;
  logic [7:0] nxt_regRdata;
  chan_adapt_pkg::tap_obs_t clampTap [5];

  // write decode
  wire wr = regReq.wrStb;
  wire [7:0] wd = regReq.wdata;
  wire wrTimer = wr && (regReq.addr == `OFS_EYE_TIMER_THR);
  wire wrDfeMerit = wr && (regReq.addr == `OFS_DFE_MERIT_CTRL);
  wire wrSwing = wr && (regReq.addr == `OFS_DRIVER_SWING);
  wire wrRateLock = wr && (regReq.addr == `OFS_RATE_LOCK_CTRL);
  wire wrIntPrbs = wr && (regReq.addr == `OFS_EYE_INT_PRBS);
  wire wrAdaptMode = wr && (regReq.addr == `OFS_ADAPT_MODE);
  wire wrIntThr = wr && (regReq.addr == `OFS_EYE_INT_THR);
  wire wrHandoff = wr && (regReq.addr == `OFS_HANDOFF_THR);
  wire wrLater = wr && (regReq.addr == `OFS_LATER_TAP_LIMIT);
  wire wrFirst = wr && (regReq.addr == `OFS_FIRST_TAP_LIMIT);
  wire wrIntClk = wr && (regReq.addr == `OFS_INT_CLK_MODE);
  wire wrStart = wr && (regReq.addr == `OFS_CTLE_START_INDEX);
  wire wrBoost = wr && (regReq.addr == `OFS_LOW_RATE_BOOST);
  wire wrLockCtrl = wr && (regReq.addr == `OFS_EYE_LOCK_CTRL);
  wire wrLockThr = wr && (regReq.addr == `OFS_EYE_LOCK_THR);
  wire wrMeritA = wr && (regReq.addr == `OFS_MERIT_TERM_A);
  wire wrMeritB = wr && (regReq.addr == `OFS_MERIT_TERM_B);
  wire wrMeritC = wr && (regReq.addr == `OFS_MERIT_TERM_C);
  wire wrAltMerit = wr && (regReq.addr == `OFS_ALT_MERIT_EN);
  wire wrCtleLook = wr && (regReq.addr == `OFS_CTLE_LOOK_AHEAD);
  wire rdFlagReg = regReq.rdStb && (regReq.addr == `OFS_EYE_INT_PRBS);

  // event only counts while the enable is set; set wins over read clear
  wire eyeIntGated = eyeIntEvent && intClkMode_ff[`BIT_EYE_INT_ENABLE];
  wire nxt_eyeFlag = eyeIntGated ? 1'b1 : (rdFlagReg ? 1'b0 : eyeFlag_ff);

  // tap selection for the observation window
  wire tapWin = (regReq.addr >= `OFS_TAP2_OBSERVE) && (regReq.addr <= `OFS_TAP5_OBSERVE);
  wire [7:0] tapOfs = regReq.addr - `OFS_TAP1_OBSERVE;
  wire [2:0] tapSel = tapOfs[2:0];

  tap_clamp uClamp (
    .rawTap(rawTap),
    .firstLimit(firstLimit_ff[4:0]),
    .laterLimit(laterLimit_ff[3:0]),
    .clampTap(clampTap)
  );

  // read mux: only listed bits are returned, the rest read zero
  always_comb begin
    nxt_regRdata = 8'h00;
    if (tapWin) begin
      nxt_regRdata = {3'b000, clampTap[tapSel].pol, clampTap[tapSel].weight[3:0]};
    end else begin
      case (regReq.addr)
        `OFS_EYE_RANGE_STATUS: nxt_regRdata = {1'b0, eyeRangeInUse, 5'h00};
        `OFS_EYE_TIMER_THR: nxt_regRdata = eyeTimerThr_ff;
        `OFS_DFE_MERIT_CTRL: nxt_regRdata = dfeMerit_ff;
        `OFS_DRIVER_SWING: nxt_regRdata = driverSwing_ff;
        `OFS_RATE_LOCK_CTRL: nxt_regRdata = rateLock_ff;
        `OFS_EYE_INT_PRBS: nxt_regRdata = eyeIntPrbs_ff | {3'b000, eyeFlag_ff, 4'h0};
        `OFS_ADAPT_MODE: nxt_regRdata = adaptMode_ff;
        `OFS_EYE_INT_THR: nxt_regRdata = eyeIntThr_ff;
        `OFS_HANDOFF_THR: nxt_regRdata = handoffThr_ff;
        `OFS_LATER_TAP_LIMIT: nxt_regRdata = laterLimit_ff;
        `OFS_FIRST_TAP_LIMIT: nxt_regRdata = firstLimit_ff;
        `OFS_INT_CLK_MODE: nxt_regRdata = intClkMode_ff;
        `OFS_CTLE_START_INDEX: nxt_regRdata = startIndex_ff;
        `OFS_LOW_RATE_BOOST: nxt_regRdata = lowRateBoost_ff;
        `OFS_EYE_LOCK_CTRL: nxt_regRdata = eyeLockCtrl_ff;
        `OFS_EYE_LOCK_THR: nxt_regRdata = eyeLockThr_ff;
        `OFS_MERIT_TERM_A: nxt_regRdata = meritA_ff;
        `OFS_MERIT_TERM_B: nxt_regRdata = meritB_ff;
        `OFS_MERIT_TERM_C: nxt_regRdata = meritC_ff;
        `OFS_ALT_MERIT_EN: nxt_regRdata = altMerit_ff;
        `OFS_CTLE_LOOK_AHEAD: nxt_regRdata = ctleLook_ff;
        `OFS_TAP1_OBSERVE: nxt_regRdata = {2'b00, clampTap[0].pol, clampTap[0].weight};
        default: nxt_regRdata = 8'h00;
      endcase
    end
  end

  // masks keep unlisted bits at zero whatever the host writes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      eyeTimerThr_ff <= `RST_EYE_TIMER_THR;
      dfeMerit_ff <= `RST_DFE_MERIT_CTRL;
      driverSwing_ff <= `RST_DRIVER_SWING;
      rateLock_ff <= `RST_RATE_LOCK_CTRL;
      eyeIntPrbs_ff <= `RST_EYE_INT_PRBS;
      adaptMode_ff <= `RST_ADAPT_MODE;
      eyeIntThr_ff <= `RST_EYE_INT_THR;
      handoffThr_ff <= `RST_HANDOFF_THR;
      laterLimit_ff <= `RST_LATER_TAP_LIMIT;
      firstLimit_ff <= `RST_FIRST_TAP_LIMIT;
      intClkMode_ff <= `RST_INT_CLK_MODE;
      startIndex_ff <= `RST_CTLE_START_INDEX;
      lowRateBoost_ff <= `RST_LOW_RATE_BOOST;
      eyeLockCtrl_ff <= `RST_EYE_LOCK_CTRL;
      eyeLockThr_ff <= `RST_EYE_LOCK_THR;
      meritA_ff <= `RST_MERIT_TERM;
      meritB_ff <= `RST_MERIT_TERM;
      meritC_ff <= `RST_MERIT_TERM;
      altMerit_ff <= `RST_ALT_MERIT_EN;
      ctleLook_ff <= `RST_CTLE_LOOK_AHEAD;
      eyeFlag_ff <= 1'b0;
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      if (wrTimer) eyeTimerThr_ff <= wd;
      if (wrDfeMerit) dfeMerit_ff <= wd & `MSK_DFE_MERIT_CTRL;
      if (wrSwing) driverSwing_ff <= wd & `MSK_DRIVER_SWING;
      if (wrRateLock) rateLock_ff <= wd & `MSK_RATE_LOCK_CTRL;
      if (wrIntPrbs) eyeIntPrbs_ff <= wd & `MSK_EYE_INT_PRBS;
      if (wrAdaptMode) adaptMode_ff <= wd & `MSK_ADAPT_MODE;
      if (wrIntThr) eyeIntThr_ff <= wd;
      if (wrHandoff) handoffThr_ff <= wd;
      if (wrLater) laterLimit_ff <= wd & `MSK_LATER_TAP_LIMIT;
      if (wrFirst) firstLimit_ff <= wd & `MSK_FIRST_TAP_LIMIT;
      if (wrIntClk) intClkMode_ff <= wd & `MSK_INT_CLK_MODE;
      if (wrStart) startIndex_ff <= wd & `MSK_CTLE_START_INDEX;
      if (wrBoost) lowRateBoost_ff <= wd;
      if (wrLockCtrl) eyeLockCtrl_ff <= wd & `MSK_EYE_LOCK_CTRL;
      if (wrLockThr) eyeLockThr_ff <= wd;
      if (wrMeritA) meritA_ff <= wd;
      if (wrMeritB) meritB_ff <= wd;
      if (wrMeritC) meritC_ff <= wd;
      if (wrAltMerit) altMerit_ff <= wd & `MSK_ALT_MERIT_EN;
      if (wrCtleLook) ctleLook_ff <= wd & `MSK_CTLE_LOOK_AHEAD;
      eyeFlag_ff <= nxt_eyeFlag;
      regRdata <= regReq.rdStb ? nxt_regRdata : regRdata;
      regRvalid <= regReq.rdStb;
    end
  end

  // registered copies so every output leaves a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adaptCfg <= '0;
      eyeIntPending <= 1'b0;
      for (int k = 0; k < 5; k++) begin
        appliedTap[k] <= '0;
      end
    end else begin
      adaptCfg.rate <= rateLock_ff[7:6];
      adaptCfg.subrate <= rateLock_ff[5:4];
      adaptCfg.startPointOverride <= rateLock_ff[`BIT_INDEX_OVERRIDE];
      adaptCfg.ppmCheckOn <= rateLock_ff[`BIT_PPM_CHECK];
      adaptCfg.falseLockOn <= ~rateLock_ff[`BIT_FALSE_LOCK_OFF];
      adaptCfg.ctleAdaptGo <= rateLock_ff[`BIT_CTLE_ADAPT_GO];
      // index is held at zero unless the override is set
      adaptCfg.ctleStartIndex <= rateLock_ff[`BIT_INDEX_OVERRIDE] ? startIndex_ff[4:0] : 5'h00;
      adaptCfg.adaptMode <= adaptMode_ff[6:5];
      adaptCfg.ctleMeritKind <= adaptMode_ff[4:3];
      adaptCfg.feedbackMeritKind <= dfeMerit_ff[5:4];
      adaptCfg.feedbackLookAhead <= dfeMerit_ff[3:0];
      adaptCfg.ctleLookAheadCount <= ctleLook_ff[2:0];
      adaptCfg.handoffHoriz <= handoffThr_ff[7:4];
      adaptCfg.handoffVert <= handoffThr_ff[3:0];
      adaptCfg.firstTapLimit <= firstLimit_ff[4:0];
      adaptCfg.laterTapLimit <= laterLimit_ff[3:0];
      adaptCfg.altMeritCtle <= altMerit_ff[`BIT_ALT_MERIT_CTLE];
      adaptCfg.altMeritDfe <= altMerit_ff[`BIT_ALT_MERIT_DFE];
      adaptCfg.meritTermA <= meritA_ff;
      adaptCfg.meritTermB <= meritB_ff;
      adaptCfg.meritTermC <= meritC_ff;
      adaptCfg.eyeLockWatchOn <= eyeLockCtrl_ff[`BIT_EYE_LOCK_WATCH];
      adaptCfg.eyeLockVert <= eyeLockThr_ff[7:4];
      adaptCfg.eyeLockHoriz <= eyeLockThr_ff[3:0];
      adaptCfg.eyeTimerThr <= eyeTimerThr_ff;
      adaptCfg.lowRateBoostStage0 <= lowRateBoost_ff[7:6];
      adaptCfg.lowRateBoostStage1 <= lowRateBoost_ff[5:4];
      adaptCfg.lowRateBoostStage2 <= lowRateBoost_ff[3:2];
      adaptCfg.lowRateBoostStage3 <= lowRateBoost_ff[1:0];
      adaptCfg.prbsEnable <= eyeIntPrbs_ff[`BIT_PRBS_ENABLE];
      adaptCfg.prbsPattern <= eyeIntPrbs_ff[1:0];
      adaptCfg.refClockMode <= intClkMode_ff[5:4];
      adaptCfg.capRangeOverride <= intClkMode_ff[`BIT_CAP_RANGE_OVERRIDE];
      adaptCfg.capRangeValue <= intClkMode_ff[1:0];
      adaptCfg.driverSwing <= driverSwing_ff[2:0];
      adaptCfg.eyeIntHoriz <= eyeIntThr_ff[7:4];
      adaptCfg.eyeIntVert <= eyeIntThr_ff[3:0];
      eyeIntPending <= nxt_eyeFlag;
      for (int k = 0; k < 5; k++) begin
        appliedTap[k] <= clampTap[k];
      end
    end
  end
endmodule : retimer_channel_adapt_cfg_regs

// file: bench/chan_adapt_cfg_monitor.sv
`timescale 1ns/1ns
module chan_adapt_cfg_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // host register port
  input wire chan_adapt_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  // loop side and settings
  input wire logic eyeIntEvent,
  input wire logic [1:0] eyeRangeInUse,
  input wire chan_adapt_pkg::tap_obs_t rawTap [5],
  input wire chan_adapt_pkg::adapt_cfg_t adaptCfg,
  input wire logic eyeIntPending,
  input wire chan_adapt_pkg::tap_obs_t appliedTap [5]
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire flagRead = regReq.rdStb && regReq.addr == 8'h30;
  // limit and raw tap quiet long enough for the registered clamp to settle
  sequence s_tapOneSteady;
    ($stable(rawTap[0]) && $stable(adaptCfg.firstTapLimit)) [*3];
  endsequence
  sequence s_tapFiveSteady;
    ($stable(rawTap[4]) && $stable(adaptCfg.laterTapLimit)) [*3];
  endsequence
  property p_readAnswer;
    regReq.rdStb |=> regRvalid;
  endproperty
  a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
  property p_rdataHold;
    !regRvalid && $past(rst_b) |-> $stable(regRdata);
  endproperty
  a_rdataHold: assert property (p_rdataHold) else $error("read data moved");
  property p_flagRise;
    $rose(eyeIntPending) |-> $past(eyeIntEvent);
  endproperty
  a_flagRise: assert property (p_flagRise) else $error("flag set without event");
  property p_flagClear;
    flagRead && !eyeIntEvent |=> !eyeIntPending;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("flag not cleared");
  property p_flagSticky;
    eyeIntPending && !flagRead |=> eyeIntPending;
  endproperty
  a_flagSticky: assert property (p_flagSticky) else $error("flag lost");
  property p_startGate;
    !adaptCfg.startPointOverride |-> adaptCfg.ctleStartIndex == 5'h00;
  endproperty
  a_startGate: assert property (p_startGate) else $error("start index leaked");
  property p_tapOne;
    s_tapOneSteady |-> appliedTap[0].pol == rawTap[0].pol && appliedTap[0].weight ==
      (rawTap[0].weight > adaptCfg.firstTapLimit ? adaptCfg.firstTapLimit : rawTap[0].weight);
  endproperty
  a_tapOne: assert property (p_tapOne) else $error("tap one clamp wrong");
  property p_tapFive;
    s_tapFiveSteady |-> appliedTap[4].pol == rawTap[4].pol && appliedTap[4].weight == {1'b0,
      (rawTap[4].weight[3:0] > adaptCfg.laterTapLimit ? adaptCfg.laterTapLimit : rawTap[4].weight[3:0])};
  endproperty
  a_tapFive: assert property (p_tapFive) else $error("tap five clamp wrong");
  property p_tapOneRead;
    regReq.rdStb && regReq.addr == 8'h71 |=> regRdata == {2'b00, appliedTap[0]};
  endproperty
  a_tapOneRead: assert property (p_tapOneRead) else $error("tap one readback wrong");
  property p_rangeRead;
    regReq.rdStb && regReq.addr == 8'h29 |=> regRdata == {1'b0, $past(eyeRangeInUse), 5'h00};
  endproperty
  a_rangeRead: assert property (p_rangeRead) else $error("range readback wrong");
endmodule : chan_adapt_cfg_monitor

bind retimer_channel_adapt_cfg_regs chan_adapt_cfg_monitor i_chan_adapt_cfg_monitor (
  .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
  .eyeIntEvent(eyeIntEvent), .eyeRangeInUse(eyeRangeInUse), .rawTap(rawTap), .adaptCfg(adaptCfg),
  .eyeIntPending(eyeIntPending), .appliedTap(appliedTap)
);

// file: bench/smbus_host_model.sv
`timescale 1ns/1ns
module smbus_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output chan_adapt_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  initial regReq = '0;
  // channel is taken as selected; released address and data are inverted so stale latching shows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    regReq <= '{wrStb: 1'b0, rdStb: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge core_clk);
    regReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    regReq <= '{wrStb: 1'b0, rdStb: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    ok = regRvalid;
    d = regRdata;
  endtask : rd
endmodule : smbus_host_model

// file: bench/tb_retimer_channel_adapt_cfg_regs.sv
`timescale 1ns/1ns
module tb_retimer_channel_adapt_cfg_regs;
  typedef struct packed {logic [7:0] addr; logic [7:0] rstVal; logic [7:0] mask;} reg_row_t;
  logic core_clk;
  logic rst_b;
  chan_adapt_pkg::reg_req_t regReq;
  logic [7:0] regRdata;
  logic regRvalid;
  logic eyeIntEvent;
  logic [1:0] eyeRangeInUse;
  chan_adapt_pkg::tap_obs_t rawTap [5];
  chan_adapt_pkg::adapt_cfg_t adaptCfg;
  logic eyeIntPending;
  chan_adapt_pkg::tap_obs_t appliedTap [5];
  int fails = 0;
  int numChecks = 0;
  int cycles = 0;
  int w;
  logic [7:0] rdVal;
  logic rdOk;
  reg_row_t rows [20];

  retimer_channel_adapt_cfg_regs i_retimer_channel_adapt_cfg_regs (.core_clk(core_clk), .rst_b(rst_b),
    .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .eyeIntEvent(eyeIntEvent),
    .eyeRangeInUse(eyeRangeInUse), .rawTap(rawTap), .adaptCfg(adaptCfg), .eyeIntPending(eyeIntPending),
    .appliedTap(appliedTap));
  smbus_host_model i_smbus_host_model (.core_clk(core_clk), .regReq(regReq), .regRdata(regRdata),
    .regRvalid(regRvalid));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    i_smbus_host_model.rd(a, rdVal, rdOk);
    check_byte({7'h00, rdOk}, 8'h01);
    check_byte(rdVal, exp);
  endtask : rd_check

  task automatic pulse_event;
    @(posedge core_clk);
    eyeIntEvent <= 1'b1;
    @(posedge core_clk);
    eyeIntEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse_event

  task report_and_stop;
    $display("checks=%0d fails=%0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // budget covers roughly nineteen times the expected run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    rst_b = 1'b0;
    eyeIntEvent = 1'b0;
    eyeRangeInUse = 2'b11;
    for (int k = 0; k < 5; k++) rawTap[k] = '{pol: k[0], weight: 5'(3 * k + 2)};
    rawTap[0] = '{pol: 1'b1, weight: 5'h1E};
    rows = '{'{8'h2A, 8'h30, 8'hFF},
      '{8'h2C, 8'h32, 8'h3F},
      '{8'h2D, 8'h00, 8'h07},
      '{8'h2F, 8'h06, 8'hFF},
      '{8'h30, 8'h00, 8'h0B},
      '{8'h31, 8'h20, 8'h78},
      '{8'h32, 8'h11, 8'hFF},
      '{8'h33, 8'h88, 8'hFF},
      '{8'h34, 8'h0F, 8'h0F},
      '{8'h35, 8'h1F, 8'h1F},
      '{8'h36, 8'h31, 8'h77},
      '{8'h39, 8'h00, 8'h1F},
      '{8'h3A, 8'hA5, 8'hFF},
      '{8'h3E, 8'h80, 8'h80},
      '{8'h6A, 8'h44, 8'hFF},
      '{8'h6B, 8'h00, 8'hFF},
      '{8'h6C, 8'h00, 8'hFF},
      '{8'h6D, 8'h00, 8'hFF},
      '{8'h6E, 8'h00, 8'hC0},
      '{8'h70, 8'h03, 8'h07}};
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) rd_check(rows[i].addr, rows[i].rstVal);
    rd_check(8'h29, 8'h60);
    i_smbus_host_model.wr(8'h29, 8'h00);
    rd_check(8'h29, 8'h60);
    foreach (rows[i]) begin
      i_smbus_host_model.wr(rows[i].addr, 8'hFF);
      rd_check(rows[i].addr, rows[i].mask);
    end
    repeat (2) @(posedge core_clk);
    check_byte({3'h0, adaptCfg.ctleStartIndex}, 8'h1F);
    check_byte({7'h00, adaptCfg.falseLockOn}, 8'h00);
    i_smbus_host_model.wr(8'h2F, 8'h00);
    repeat (2) @(posedge core_clk);
    check_byte({3'h0, adaptCfg.ctleStartIndex}, 8'h00);
    check_byte({6'h00, adaptCfg.falseLockOn, adaptCfg.ppmCheckOn}, 8'h02);
    foreach (rows[i]) begin
      i_smbus_host_model.wr(rows[i].addr, 8'h00);
      rd_check(rows[i].addr, 8'h00);
    end
    i_smbus_host_model.wr(8'h80, 8'hFF);
    rd_check(8'h80, 8'h00);
    // tap one above its limit, later taps sit at or above a limit of five
    i_smbus_host_model.wr(8'h35, 8'h10);
    i_smbus_host_model.wr(8'h34, 8'h05);
    i_smbus_host_model.wr(8'h71, 8'hFF);
    rd_check(8'h71, 8'h30);
    for (int k = 1; k < 5; k++) begin
      w = (3 * k + 2 > 5) ? 5 : 3 * k + 2;
      rd_check(8'(8'h71 + k), {3'h0, k[0], 4'(w)});
    end
    pulse_event();
    rd_check(8'h30, 8'h00);
    i_smbus_host_model.wr(8'h36, 8'h40);
    pulse_event();
    check_byte({7'h00, eyeIntPending}, 8'h01);
    rd_check(8'h30, 8'h10);
    rd_check(8'h30, 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_check(8'h2F, 8'h06);
    rd_check(8'h36, 8'h31);
    // settings handed on must carry the reset values again
    check_byte({adaptCfg.eyeIntHoriz, adaptCfg.eyeIntVert}, 8'h11);
    check_byte({adaptCfg.handoffHoriz, adaptCfg.handoffVert}, 8'h88);
    check_byte({adaptCfg.eyeLockVert, adaptCfg.eyeLockHoriz}, 8'h44);
    check_byte({adaptCfg.lowRateBoostStage0, adaptCfg.lowRateBoostStage1,
      adaptCfg.lowRateBoostStage2, adaptCfg.lowRateBoostStage3}, 8'hA5);
    check_byte({1'b0, adaptCfg.adaptMode, adaptCfg.ctleMeritKind, 3'h0}, 8'h20);
    check_byte({2'h0, adaptCfg.feedbackMeritKind, adaptCfg.feedbackLookAhead}, 8'h32);
    check_byte({5'h00, adaptCfg.ctleLookAheadCount}, 8'h03);
    check_byte(adaptCfg.eyeTimerThr, 8'h30);
    check_byte({adaptCfg.eyeLockWatchOn, 2'h0, adaptCfg.firstTapLimit}, 8'h9F);
    check_byte({2'h0, adaptCfg.refClockMode, 1'b0, adaptCfg.capRangeOverride, adaptCfg.capRangeValue}, 8'h31);
    check_byte({2'h0, adaptCfg.altMeritCtle, adaptCfg.altMeritDfe, adaptCfg.laterTapLimit}, 8'h0F);
    check_byte({4'h0, adaptCfg.prbsEnable, 1'b0, adaptCfg.prbsPattern}, 8'h00);
    report_and_stop();
  end
endmodule : tb_retimer_channel_adapt_cfg_regs
